// ### rtl/dpr_cfg.svh
// Constants for the dual-port RAM clocking and port-control block.
// Assumes inclusion by bare name from the package and the design files.
`ifndef DPR_CFG_SVH
`define DPR_CFG_SVH

`define DPR_ADDR_W        16
`define DPR_BE_W          8
`define DPR_BYTE_W        9
`define DPR_DATA_W        72
`define DPR_SLICE_W       12
`define DPR_MEM_AW        13
`define DPR_MEM_WORDS     8192
`define DPR_SPLIT_BITS    2048
`define DPR_SPLIT_WORDS   (`DPR_SPLIT_BITS / `DPR_DATA_W)
`define DPR_SPLIT_BASE_B  13'h1000

`define DPR_OFF_CTRL      12'h000
`define DPR_OFF_STAT      12'h004
`define DPR_CTRL_RST      6'h00
`define DPR_CTRL_W        6
`define DPR_CTRL_MODE_LSB 0
`define DPR_CTRL_SIMPLE   2
`define DPR_CTRL_BYP_A    3
`define DPR_CTRL_BYP_B    4
`define DPR_CTRL_SPLIT    5
`define DPR_STAT_CNTB_LSB 16

`endif

// ### rtl/dpr_pkg.sv
// Types shared by the dual-port RAM control files.
// Assumes dpr_cfg.svh is on the include path.
`include "dpr_cfg.svh"

package dpr_pkg;
    typedef enum logic [1:0] {
        DPR_MODE_IND,
        DPR_MODE_IO,
        DPR_MODE_RW,
        DPR_MODE_SINGLE
    } dpr_mode_t;

    typedef logic [`DPR_DATA_W-1:0] dpr_word_t;
    typedef logic [`DPR_MEM_AW-1:0] dpr_maddr_t;
endpackage

// ### rtl/dpr_mem.sv
// Two-port storage array with byte enables and registered read data.
// Assumes both ports are driven on pclk; a same-cycle write collision lets port B win.
`timescale 1ns/1ns
`default_nettype none
`include "dpr_cfg.svh"

module dpr_mem
    import dpr_pkg::*;
(
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 a_we,
    input  wire logic                 a_re,
    input  wire dpr_maddr_t           a_addr,
    input  wire logic [`DPR_BE_W-1:0] a_be,
    input  wire dpr_word_t            a_wd,
    output dpr_word_t                 a_q,
    input  wire logic                 b_we,
    input  wire logic                 b_re,
    input  wire dpr_maddr_t           b_addr,
    input  wire logic [`DPR_BE_W-1:0] b_be,
    input  wire dpr_word_t            b_wd,
    output dpr_word_t                 b_q
);
    dpr_word_t mem [`DPR_MEM_WORDS];
    dpr_word_t a_q_nxt;
    dpr_word_t b_q_nxt;

    always_ff @(posedge pclk) begin
        for (int i = 0; i < `DPR_BE_W; i++) begin
            if (a_we && a_be[i]) begin
                mem[a_addr][i*`DPR_BYTE_W +: `DPR_BYTE_W] <= a_wd[i*`DPR_BYTE_W +: `DPR_BYTE_W];
            end
            if (b_we && b_be[i]) begin
                mem[b_addr][i*`DPR_BYTE_W +: `DPR_BYTE_W] <= b_wd[i*`DPR_BYTE_W +: `DPR_BYTE_W];
            end
        end
    end

    always_comb begin
        a_q_nxt = a_re ? mem[a_addr] : a_q;
        b_q_nxt = b_re ? mem[b_addr] : b_q;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            a_q <= '0;
            b_q <= '0;
        end else begin
            a_q <= a_q_nxt;
            b_q <= b_q_nxt;
        end
    end
endmodule
`default_nettype wire

// ### rtl/dpr_ctrl.sv
// Port control and clocking modes of a dual-port RAM block, with an APB register slave.
// Assumes all port strobes come from pclk logic; port clocks arrive as one-cycle tick enables.
//
// The APB register port and the address map were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "dpr_cfg.svh"

module dpr_ctrl
    import dpr_pkg::*;
(
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [11:0]            paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire logic                   in_tick_a,
    input  wire logic                   in_ce_a,
    input  wire logic                   in_clr_a,
    input  wire logic                   out_tick_a,
    input  wire logic                   out_ce_a,
    input  wire logic                   out_clr_a,
    input  wire logic [`DPR_ADDR_W-1:0] addr_a,
    input  wire logic [`DPR_BE_W-1:0]   byte_en_a,
    input  wire logic                   rw_en_a,
    input  wire dpr_word_t              wdata_a,
    output dpr_word_t                   rdata_a,
    input  wire logic                   in_tick_b,
    input  wire logic                   in_ce_b,
    input  wire logic                   in_clr_b,
    input  wire logic                   out_tick_b,
    input  wire logic                   out_ce_b,
    input  wire logic                   out_clr_b,
    input  wire logic [`DPR_ADDR_W-1:0] addr_b,
    input  wire logic [`DPR_BE_W-1:0]   byte_en_b,
    input  wire logic                   rw_en_b,
    input  wire dpr_word_t              wdata_b,
    output dpr_word_t                   rdata_b
);
    // Register bank state.
    logic [`DPR_CTRL_W-1:0] ctrl_r;
    logic [`DPR_CTRL_W-1:0] ctrl_nxt;
    logic [31:0]            prdata_r;
    logic [31:0]            prdata_nxt;
    dpr_mode_t              mode;
    logic                   simple;
    logic                   split;
    logic [1:0]             bypass;

    // Per-port signals packed by port index, 0 is port A.
    wire  [1:0]                   in_tick  = {in_tick_b, in_tick_a};
    wire  [1:0]                   in_ce    = {in_ce_b, in_ce_a};
    wire  [1:0]                   in_clr   = {in_clr_b, in_clr_a};
    wire  [1:0]                   out_tick = {out_tick_b, out_tick_a};
    wire  [1:0]                   out_ce   = {out_ce_b, out_ce_a};
    wire  [1:0]                   out_clr  = {out_clr_b, out_clr_a};
    wire  [1:0]                   rw_en    = {rw_en_b, rw_en_a};
    wire  [1:0][`DPR_ADDR_W-1:0]  addr_in  = {addr_b, addr_a};
    wire  [1:0][`DPR_BE_W-1:0]    be_in    = {byte_en_b, byte_en_a};
    wire  [1:0][`DPR_DATA_W-1:0]  wd_in    = {wdata_b, wdata_a};
    wire  [1:0]                   mem_we;
    wire  [1:0]                   mem_re;
    wire  [1:0][`DPR_MEM_AW-1:0]  mem_addr;
    wire  [1:0][`DPR_BE_W-1:0]    mem_be;
    wire  [1:0][`DPR_DATA_W-1:0]  mem_wd;
    wire  [1:0][`DPR_DATA_W-1:0]  mem_q;
    wire  [1:0][`DPR_DATA_W-1:0]  dout;
    wire  [1:0][15:0]             wcnt;

    function automatic logic reg_hit(input logic [11:0] a);
        reg_hit = (a == `DPR_OFF_CTRL) || (a == `DPR_OFF_STAT);
    endfunction

    // Maps a port address to the array; bit 13 of the result says the word exists.
    function automatic logic [13:0] word_map(input logic [15:0] a, input logic sp, input logic hi);
        logic [12:0] base;
        base = hi ? `DPR_SPLIT_BASE_B : 13'h0000;
        if (sp) begin
            word_map = {(a < 16'(`DPR_SPLIT_WORDS)), base + a[12:0]};
        end else begin
            word_map = {(a[15:13] == 3'h0), a[12:0]};
        end
    endfunction

    always_comb begin
        mode    = dpr_mode_t'(ctrl_r[`DPR_CTRL_MODE_LSB +: 2]);
        simple  = ctrl_r[`DPR_CTRL_SIMPLE] || (mode == DPR_MODE_RW);
        split   = ctrl_r[`DPR_CTRL_SPLIT] && (mode == DPR_MODE_SINGLE);
        bypass  = {ctrl_r[`DPR_CTRL_BYP_B], ctrl_r[`DPR_CTRL_BYP_A]};
        pready  = 1'b1;
        pslverr = psel && penable && !reg_hit(paddr);
        prdata  = prdata_r;
        ctrl_nxt   = ctrl_r;
        prdata_nxt = prdata_r;
        if (psel && penable && pwrite && reg_hit(paddr) && (paddr == `DPR_OFF_CTRL)) begin
            ctrl_nxt = pwdata[`DPR_CTRL_W-1:0];
        end
        // Read data is fetched in the setup cycle so the zero-wait access sees a flop.
        if (psel && !penable && !pwrite) begin
            prdata_nxt = '0;
            if (paddr == `DPR_OFF_CTRL) begin
                prdata_nxt[`DPR_CTRL_W-1:0] = ctrl_r;
            end else if (paddr == `DPR_OFF_STAT) begin
                prdata_nxt = {wcnt[1], wcnt[0]};
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r   <= `DPR_CTRL_RST;
            prdata_r <= '0;
        end else begin
            ctrl_r   <= ctrl_nxt;
            prdata_r <= prdata_nxt;
        end
    end

    for (genvar p = 0; p < 2; p++) begin : g_port
        logic [`DPR_ADDR_W-1:0] addr_r;
        logic [`DPR_ADDR_W-1:0] addr_nxt;
        logic [`DPR_BE_W-1:0]   be_r;
        logic [`DPR_BE_W-1:0]   be_nxt;
        logic                   we_r;
        logic                   we_nxt;
        dpr_word_t              din_r;
        dpr_word_t              din_nxt;
        logic                   issue_r;
        logic                   issue_nxt;
        logic                   rden_r;
        logic                   rden_nxt;
        dpr_word_t              out_r;
        dpr_word_t              out_nxt;
        logic [15:0]            cnt_r;
        logic [15:0]            cnt_nxt;
        logic                   in_go;
        logic                   out_go;
        logic                   out_kill;
        logic                   live;
        logic [13:0]            map;
        logic                   wr_ok;
        logic                   rd_ok;

        always_comb begin
            in_go = in_tick[p] && in_ce[p];
            if (mode == DPR_MODE_IO) begin
                out_go   = out_tick[p] && out_ce[p];
                out_kill = out_clr[p];
            end else begin
                out_go   = in_go;
                out_kill = in_clr[p];
            end
            live = (mode != DPR_MODE_SINGLE) || (p == 0) || split;
            map  = word_map(addr_r, split, p == 1);
            wr_ok = issue_r && map[13] && we_r && (!simple || (p == 0));
            rd_ok = issue_r && map[13] && (simple ? (rden_r && (p == 1)) : !we_r);
            addr_nxt  = addr_r;
            be_nxt    = be_r;
            we_nxt    = we_r;
            din_nxt   = din_r;
            issue_nxt = 1'b0;
            rden_nxt  = rden_r;
            if (in_clr[p]) begin
                addr_nxt = '0;
                be_nxt   = '0;
                we_nxt   = 1'b0;
                din_nxt  = '0;
            end else if (in_go) begin
                addr_nxt  = addr_in[p];
                be_nxt    = be_in[p];
                we_nxt    = rw_en[p];
                din_nxt   = wd_in[p];
                issue_nxt = live;
            end
            if (in_go && simple) begin
                rden_nxt = rw_en[p];
            end
            out_nxt = out_r;
            if (out_kill) begin
                out_nxt = '0;
            end else if (out_go) begin
                out_nxt = mem_q[p];
            end
            cnt_nxt = wr_ok ? 16'(cnt_r + 16'h0001) : cnt_r;
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                addr_r  <= '0;
                be_r    <= '0;
                we_r    <= 1'b0;
                din_r   <= '0;
                issue_r <= 1'b0;
                out_r   <= '0;
                cnt_r   <= '0;
            end else begin
                addr_r  <= addr_nxt;
                be_r    <= be_nxt;
                we_r    <= we_nxt;
                din_r   <= din_nxt;
                issue_r <= issue_nxt;
                out_r   <= out_nxt;
                cnt_r   <= cnt_nxt;
            end
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                rden_r <= 1'b0;
            end else begin
                rden_r <= rden_nxt;
            end
        end

        assign mem_we[p]   = wr_ok;
        assign mem_re[p]   = rd_ok;
        assign mem_addr[p] = map[12:0];
        assign mem_be[p]   = be_r;
        assign mem_wd[p]   = din_r;
        assign wcnt[p]     = cnt_r;
        assign dout[p]     = bypass[p] ? mem_q[p] : out_r;
    end

    // 72-bit words, slice 5 is bits 71..60
    assign rdata_a = dout[0];
    assign rdata_b = dout[1];

    dpr_mem dpr_mem_inst (
        .pclk    (pclk),
        .presetn (presetn),
        .a_we    (mem_we[0]),
        .a_re    (mem_re[0]),
        .a_addr  (mem_addr[0]),
        .a_be    (mem_be[0]),
        .a_wd    (mem_wd[0]),
        .a_q     (mem_q[0]),
        .b_we    (mem_we[1]),
        .b_re    (mem_re[1]),
        .b_addr  (mem_addr[1]),
        .b_be    (mem_be[1]),
        .b_wd    (mem_wd[1]),
        .b_q     (mem_q[1])
    );
endmodule
`default_nettype wire

// ### tb/dpr_ctrl_sva.sv
// Assertions on the APB and data ports of the RAM port control block.
// Assumes CTRL changes only through APB writes that these ports show.
`timescale 1ns/1ns
`default_nettype none
`include "dpr_cfg.svh"

module dpr_ctrl_sva
    import dpr_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        in_tick_a,
    input wire logic        in_ce_a,
    input wire logic        in_clr_a,
    input wire logic        out_tick_a,
    input wire logic        out_clr_a,
    input wire logic        in_tick_b,
    input wire logic        in_clr_b,
    input wire logic        out_tick_b,
    input wire logic        out_clr_b,
    input wire dpr_word_t   rdata_a,
    input wire dpr_word_t   rdata_b
);
    logic [5:0] ctl_r;
    logic [5:0] ctl_nxt;
    logic       quiet_a;
    logic       quiet_b;

    always_comb begin
        ctl_nxt = ctl_r;
        if (psel && penable && pwrite && paddr == `DPR_OFF_CTRL) begin
            ctl_nxt = pwdata[5:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_r <= `DPR_CTRL_RST;
        end else begin
            ctl_r <= ctl_nxt;
        end
    end

    // Any APB cycle counts as activity, since a mode change may move the read mux.
    assign quiet_a = !(in_tick_a || out_tick_a || in_clr_a || out_clr_a || psel);
    assign quiet_b = !(in_tick_b || out_tick_b || in_clr_b || out_clr_b || psel);

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_hold_port_a:
        assert property (quiet_a [*3] |=> $stable(rdata_a)) else $error("rdata_a moved while port A idle");
    a_hold_port_b:
        assert property (quiet_b [*3] |=> $stable(rdata_b)) else $error("rdata_b moved while port B idle");
    a_reset_clean:
        assert property ($rose(presetn) |-> rdata_a == '0 && rdata_b == '0 && prdata == 32'h0)
        else $error("outputs not clear after reset");
    a_clr_ind_b:
        assert property (ctl_r[1:0] == DPR_MODE_IND && !ctl_r[`DPR_CTRL_BYP_B] && in_clr_b |=> rdata_b == '0)
        else $error("port B clear missed");
    a_clr_io_a:
        assert property (ctl_r[1:0] == DPR_MODE_IO && !ctl_r[`DPR_CTRL_BYP_A] && out_clr_a |=> rdata_a == '0)
        else $error("port A output clear missed");
    a_bypass_time:
        assert property (ctl_r[1:0] == DPR_MODE_IND && ctl_r[`DPR_CTRL_BYP_A] && $stable(ctl_r) && $changed(rdata_a)
            |-> $past(in_tick_a && in_ce_a, 2) || $past(in_clr_a) || $past(in_clr_a, 2))
        else $error("bypassed read data at wrong time");
    a_prdata_load:
        assert property ($changed(prdata) |-> $past(psel && !penable && !pwrite)) else $error("prdata moved");
    a_err_map:
        assert property (pslverr == (psel && penable && paddr != `DPR_OFF_CTRL && paddr != `DPR_OFF_STAT))
        else $error("pslverr wrong");
endmodule

bind dpr_ctrl dpr_ctrl_sva dpr_ctrl_sva_inst (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pslverr,
    .in_tick_a, .in_ce_a, .in_clr_a, .out_tick_a, .out_clr_a,
    .in_tick_b, .in_clr_b, .out_tick_b, .out_clr_b, .rdata_a, .rdata_b
);
`default_nettype wire

// ### tb/dpr_fab.sv
// Fabric-side driver for one data port of the RAM control block.
// Assumes op is called for one transfer at a time, from a single process.
`timescale 1ns/1ns
`default_nettype none
`include "dpr_cfg.svh"

module dpr_fab
    import dpr_pkg::*;
(
    input  wire logic              pclk,
    output logic                   tick,
    output logic                   ce,
    output logic [`DPR_ADDR_W-1:0] addr,
    output logic [`DPR_BE_W-1:0]   be,
    output logic                   rw,
    output dpr_word_t              wd
);
    initial begin
        tick = 1'b0;
        ce = 1'b0;
        addr = '0;
        be = 8'hff;
        rw = 1'b0;
        wd = '0;
    end

    // One tick carries address, enables and a whole word.
    task automatic op(input logic w, input logic [15:0] a, input logic [7:0] b, input dpr_word_t d, input logic e);
        @(posedge pclk);
        tick <= 1'b1;
        ce <= e;
        rw <= w;
        addr <= a;
        be <= b;
        wd <= d;
        @(posedge pclk);
        // Released lines flip, so a late capture shows up as wrong data.
        tick <= 1'b0;
        ce <= 1'b0;
        rw <= ~w;
        addr <= ~a;
        be <= ~b;
        wd <= ~d;
    endtask
endmodule
`default_nettype wire

// ### tb/test_dpr_ctrl.sv
// Self-checking bench for the RAM port control block.
// Assumes the fabric models drive both data ports; the bench owns APB and the clears.
`timescale 1ns/1ns
`default_nettype none
`include "dpr_cfg.svh"

`define CK(g, e) begin n_compared++; if ((g) !== (e)) begin n_errors++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end

module test_dpr_ctrl
    import dpr_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic        in_tick_a, in_ce_a, in_clr_a, out_tick_a, out_ce_a, out_clr_a, rw_en_a;
    logic        in_tick_b, in_ce_b, in_clr_b, out_tick_b, out_ce_b, out_clr_b, rw_en_b;
    logic [15:0] addr_a, addr_b;
    logic [7:0]  byte_en_a, byte_en_b;
    dpr_word_t   wdata_a, wdata_b, rdata_a, rdata_b;
    int          n_errors = 0;
    int          n_compared = 0;
    localparam dpr_word_t   D1 = 72'hfed_cba_987_654_321_0f1;
    localparam dpr_word_t   D2 = 72'h5a5_a5a_0ff_f00_123_456;
    localparam dpr_word_t   D3 = 72'h001_002_004_008_010_020;
    localparam logic [31:0] BA = 32'h1 << `DPR_CTRL_BYP_A;
    localparam logic [31:0] BB = 32'h1 << `DPR_CTRL_BYP_B;
    localparam logic [31:0] SP = 32'h1 << `DPR_CTRL_SPLIT;

    dpr_ctrl dpr_ctrl_inst (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .in_tick_a, .in_ce_a, .in_clr_a, .out_tick_a, .out_ce_a, .out_clr_a,
        .addr_a, .byte_en_a, .rw_en_a, .wdata_a, .rdata_a,
        .in_tick_b, .in_ce_b, .in_clr_b, .out_tick_b, .out_ce_b, .out_clr_b,
        .addr_b, .byte_en_b, .rw_en_b, .wdata_b, .rdata_b
    );
    dpr_fab fab_a (.pclk, .tick(in_tick_a), .ce(in_ce_a), .addr(addr_a), .be(byte_en_a), .rw(rw_en_a), .wd(wdata_a));
    dpr_fab fab_b (.pclk, .tick(in_tick_b), .ce(in_ce_b), .addr(addr_b), .be(byte_en_b), .rw(rw_en_b), .wd(wdata_b));

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    task automatic results();
        if (n_errors == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (4000) @(posedge pclk);
        n_errors++;
        results();
    end

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a wait that never sees pready.
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        `CK(pready, 1'b1)
        if (!w && !e) `CK(prdata, d)
        `CK(pslverr, e)
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {out_tick_a, out_ce_a, out_clr_a, in_clr_a, out_tick_b, out_ce_b, out_clr_b, in_clr_b} = '0;
        presetn = 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, `DPR_OFF_CTRL, 32'h0, 0);
        apb(0, 12'h008, 32'h0, 1);
        apb(1, `DPR_OFF_CTRL, BA, 0);
        fab_a.op(1, 16'd5, 8'hff, D1, 1);
        fab_a.op(1, 16'd6, 8'hff, D2, 1);
        fab_a.op(1, 16'd5, 8'h01, ~D1, 1);
        fab_a.op(1, 16'd5, 8'hff, D3, 0);
        apb(0, `DPR_OFF_STAT, 32'h3, 0);
        apb(1, `DPR_OFF_STAT, 32'hffffffff, 0);
        apb(0, `DPR_OFF_STAT, 32'h3, 0);
        fab_a.op(1, 16'h2005, 8'hff, D3, 1);
        fab_a.op(0, 16'd5, 8'hff, D3, 1);
        @(posedge pclk);
        #1 `CK(rdata_a, {D1[71:9], ~D1[8:0]})
        fab_b.op(0, 16'd6, 8'hff, D3, 1);
        fab_b.op(0, 16'd5, 8'hff, D3, 1);
        #1 `CK(rdata_b, D2)
        @(posedge pclk) in_clr_b <= 1'b1;
        @(posedge pclk) in_clr_b <= 1'b0;
        #1 `CK(rdata_b, 72'h0)
        apb(1, `DPR_OFF_CTRL, 32'(DPR_MODE_IO), 0);
        fab_a.op(0, 16'd6, 8'hff, D3, 1);
        repeat (2) @(posedge pclk);
        out_tick_a <= 1'b1;
        out_ce_a <= 1'b1;
        @(posedge pclk) out_tick_a <= 1'b0;
        #1 `CK(rdata_a, D2)
        @(posedge pclk) in_clr_a <= 1'b1;
        @(posedge pclk) in_clr_a <= 1'b0;
        #1 `CK(rdata_a, D2)
        @(posedge pclk) out_clr_a <= 1'b1;
        @(posedge pclk) out_clr_a <= 1'b0;
        #1 `CK(rdata_a, 72'h0)
        apb(1, `DPR_OFF_CTRL, 32'(DPR_MODE_RW) | BB, 0);
        fab_a.op(1, 16'd9, 8'hff, D3, 1);
        fab_b.op(1, 16'd9, 8'hff, D1, 1);
        @(posedge pclk);
        #1 `CK(rdata_b, D3)
        fab_b.op(0, 16'd5, 8'hff, D1, 1);
        @(posedge pclk) in_clr_a <= 1'b1;
        @(posedge pclk) in_clr_a <= 1'b0;
        #1 `CK(rdata_b, D3)
        apb(1, `DPR_OFF_CTRL, 32'(DPR_MODE_SINGLE) | BA, 0);
        fab_a.op(1, 16'd7, 8'hff, D1, 1);
        fab_b.op(1, 16'd7, 8'hff, D2, 1);
        fab_a.op(0, 16'd7, 8'hff, D3, 1);
        @(posedge pclk);
        #1 `CK(rdata_a, D1)
        apb(1, `DPR_OFF_CTRL, 32'(DPR_MODE_SINGLE) | BA | BB | SP, 0);
        fab_a.op(1, 16'd3, 8'hff, D3, 1);
        fab_b.op(1, 16'd3, 8'hff, D2, 1);
        fab_a.op(0, 16'd3, 8'hff, D1, 1);
        fab_b.op(0, 16'd3, 8'hff, D1, 1);
        @(posedge pclk);
        #1 `CK(rdata_a, D3)
        `CK(rdata_b, D2)
        // Six port A writes landed; port B wrote once, only while split.
        apb(0, `DPR_OFF_STAT, 32'h0001_0006, 0);
        results();
    end
endmodule
`default_nettype wire
